// ==== verilog/jsh_map.vh ====
/*
 Offsets, field positions, reset values and timing counts of the job
 start handshake block. Assumes inclusion by its bare name from design files.
*/
`ifndef JSH_MAP_VH
`define JSH_MAP_VH

// -----------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------
`define JSH_OFS_CTRL      8'h00
`define JSH_OFS_STATUS    8'h04
`define JSH_OFS_IRQ_STAT  8'h08
`define JSH_OFS_IRQ_MASK  8'h0c
`define JSH_OFS_RESULT    8'h10
`define JSH_OFS_TIMEOUT   8'h14

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define JSH_START_BIT     1
`define JSH_ACTIVE_BIT    1
`define JSH_CTRL_ARM      0
`define JSH_CTRL_DONE     1
`define JSH_CTRL_FAIL     2
`define JSH_IRQ_LAUNCH    0
`define JSH_IRQ_DONE      1
`define JSH_IRQ_TIMEOUT   2
`define JSH_IRQ_STALE     3

// -----------------------------------------------------------------------
// Reset values, timeout error code and timing
// -----------------------------------------------------------------------
`define JSH_PRESET_STATUS 16'h0001
`define JSH_TIMEOUT_DFLT  16'h001e
`define JSH_TIMEOUT_ERR   16'h00ff
`define JSH_TICK_NS       1000000
`define JSH_CLK_NS        10
`define JSH_TICK_CYCLES   (`JSH_TICK_NS / `JSH_CLK_NS)

`endif

// ==== verilog/jsh_sync.v ====
/*
 Two-flop synchroniser for a bus of independent level signals.
 Assumes each bit is a quasi-static level from another domain.
*/
`timescale 1ns/1ps
module jsh_sync #(
   parameter W = 16
) (
   // Clock and reset.
   input  wire         clk_sys_in,
   input  wire         rst_n_in,
   // Data.
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // jsh_sync

// ==== verilog/jsh_job_start_handshake.v ====
/*
 Device end of the job start handshake: watches the host's control output
 word, raises the job active bit, runs the job timeout and writes the
 completion status word. The job engine behind it reports done or fail
 through the register port. Assumes the host word arrives asynchronously.
*/
`timescale 1ns/1ps
`include "jsh_map.vh"

module jsh_job_start_handshake #(
   parameter        WORD_W      = 16,
   parameter [15:0] BLOCK_WORDS = 16'h00c8,
   parameter        TICK_CYCLES = `JSH_TICK_CYCLES
) (
   // Clock and reset.
   input  wire              clk_sys_in,
   input  wire              rst_n_in,
   // Backplane words.
   input  wire [WORD_W-1:0] job_control_output_word_in,
   output reg  [WORD_W-1:0] job_ack_input_word_out,
   output reg  [15:0]       job_completion_status_word_out,
   output reg               status_write_out,
   // Register port.
   input  wire [7:0]        addr_in,
   input  wire [31:0]       wdata_in,
   input  wire              wr_in,
   input  wire              rd_in,
   output reg  [31:0]       rdata_out,
   // Interrupt.
   output wire              irq_out
);
   // -----------------------------------------------------------------------
   // States
   // -----------------------------------------------------------------------
   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_RUN   = 2'h1;
   localparam [1:0] ST_DONE  = 2'h2;
   localparam [1:0] ST_STALE = 2'h3;

   wire [WORD_W-1:0] ctrl_s;
   wire              start_s;
   reg  [1:0]        state_q;
   reg  [1:0]        settle_q;
   reg  [15:0]       timeout_q;
   reg  [15:0]       secs_q;
   reg  [31:0]       tick_q;
   reg  [15:0]       result_q;
   reg               armed_q;
   reg  [3:0]        irq_stat_q;
   reg  [3:0]        irq_mask_q;
   reg  [3:0]        ev;
   reg               eng_done;
   reg               eng_fail;
   reg  [15:0]       eng_code;

   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   jsh_sync #(
      .W (WORD_W)
   ) u_sync (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .async_in   (job_control_output_word_in),
      .sync_out   (ctrl_s)
   );

   assign start_s = ctrl_s[`JSH_START_BIT];
   assign irq_out = |(irq_stat_q & irq_mask_q);

   // -----------------------------------------------------------------------
   // Engine report strobes
   // -----------------------------------------------------------------------
   always @* begin
      eng_done = wr_in && hit(addr_in, `JSH_OFS_CTRL) && wdata_in[`JSH_CTRL_DONE];
      eng_fail = wr_in && hit(addr_in, `JSH_OFS_CTRL) && wdata_in[`JSH_CTRL_FAIL];
      eng_code = (wdata_in[31:16] == 16'h0000) ? `JSH_TIMEOUT_ERR : wdata_in[31:16];
   end

   // -----------------------------------------------------------------------
   // Handshake state machine
   // -----------------------------------------------------------------------
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         state_q                        <= ST_STALE;
         settle_q                       <= 2'h0;
         job_ack_input_word_out         <= {WORD_W{1'b0}};
         job_completion_status_word_out <= `JSH_PRESET_STATUS;
         status_write_out               <= 1'b0;
         secs_q                         <= 16'h0000;
         tick_q                         <= 32'h0000_0000;
         result_q                       <= 16'h0000;
      end else begin
         status_write_out <= 1'b0;
         case (state_q)
            ST_STALE: begin
               // A start bit already high after recovery belongs to a lost job.
               // The synchroniser clears on reset, so its first outputs would look
               // like a released start bit; wait until it carries the pin again.
               if (settle_q != 2'h3) begin
                  settle_q <= settle_q + 2'h1;
               end else if (!start_s) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (start_s && armed_q) begin
                  job_ack_input_word_out[`JSH_ACTIVE_BIT] <= 1'b1;
                  secs_q  <= 16'h0000;
                  tick_q  <= 32'h0000_0000;
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (tick_q == TICK_CYCLES - 1) begin
                  tick_q <= 32'h0000_0000;
                  secs_q <= secs_q + 16'h0001;
               end else begin
                  tick_q <= tick_q + 32'h0000_0001;
               end
               if (eng_done || eng_fail) begin
                  job_completion_status_word_out <= eng_fail ? eng_code : 16'h0000;
                  result_q         <= eng_fail ? eng_code : 16'h0000;
                  status_write_out <= 1'b1;
                  state_q          <= ST_DONE;
               end else if (secs_q >= timeout_q) begin
                  job_completion_status_word_out <= `JSH_TIMEOUT_ERR;
                  result_q         <= `JSH_TIMEOUT_ERR;
                  status_write_out <= 1'b1;
                  state_q          <= ST_DONE;
               end
            end
            ST_DONE: begin
               if (!start_s) begin
                  job_ack_input_word_out[`JSH_ACTIVE_BIT] <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------------
   // Registers and interrupts
   // -----------------------------------------------------------------------
   always @* begin
      ev = 4'h0;
      ev[`JSH_IRQ_LAUNCH]  = (state_q == ST_IDLE) && start_s && armed_q;
      ev[`JSH_IRQ_DONE]    = (state_q == ST_RUN) && (eng_done || eng_fail);
      ev[`JSH_IRQ_TIMEOUT] = (state_q == ST_RUN) && !(eng_done || eng_fail)
                             && (secs_q >= timeout_q);
      ev[`JSH_IRQ_STALE]   = (state_q == ST_STALE) && (settle_q == 2'h3) && start_s;
   end

   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         armed_q    <= 1'b0;
         timeout_q  <= `JSH_TIMEOUT_DFLT;
         irq_stat_q <= 4'h0;
         irq_mask_q <= 4'h0;
         rdata_out  <= 32'h0000_0000;
      end else begin
         // Set wins over a write-one clear in the same cycle.
         if (wr_in && hit(addr_in, `JSH_OFS_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~wdata_in[3:0]) | ev;
         end else begin
            irq_stat_q <= irq_stat_q | ev;
         end
         if (wr_in && hit(addr_in, `JSH_OFS_CTRL)) begin
            armed_q <= wdata_in[`JSH_CTRL_ARM];
         end
         if (wr_in && hit(addr_in, `JSH_OFS_IRQ_MASK)) begin
            irq_mask_q <= wdata_in[3:0];
         end
         if (wr_in && hit(addr_in, `JSH_OFS_TIMEOUT)) begin
            timeout_q <= wdata_in[15:0];
         end
         rdata_out <= 32'h0000_0000;
         if (rd_in) begin
            case (addr_in)
               `JSH_OFS_CTRL:     rdata_out <= {31'h0, armed_q};
               `JSH_OFS_STATUS:   rdata_out <= {14'h0, state_q, ctrl_s[15:0] & 16'hffff};
               `JSH_OFS_IRQ_STAT: rdata_out <= {28'h0, irq_stat_q};
               `JSH_OFS_IRQ_MASK: rdata_out <= {28'h0, irq_mask_q};
               `JSH_OFS_RESULT:   rdata_out <= {result_q, 16'h0000};
               // Block size is reported so both ends can match it.
               `JSH_OFS_TIMEOUT:  rdata_out <= {BLOCK_WORDS, timeout_q};
               default:           rdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // jsh_job_start_handshake

// ==== sim/jsh_chk_chk.sv ====
/* Port assertions for the job start handshake block.
   Assumes a bind onto the top module and a single clock domain. */
`timescale 1ns/1ps
module jsh_chk #(parameter WORD_W = 16) (
   // Clock and reset.
   input wire logic              clk_sys_in,
   input wire logic              rst_n_in,
   // Backplane words.
   input wire logic [WORD_W-1:0] job_control_output_word_in,
   input wire logic [WORD_W-1:0] job_ack_input_word_out,
   input wire logic [15:0]       job_completion_status_word_out,
   input wire logic              status_write_out,
   // Register port and interrupt.
   input wire logic              rd_in,
   input wire logic [31:0]       rdata_out,
   input wire logic              irq_out
);
   wire logic st = job_control_output_word_in[1];
   wire logic act = job_ack_input_word_out[1];
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // The reset guards keep a mid-run reset from looking like an edge.
   property p_rise; $rose(act) && $past(rst_n_in) |-> $past(st, 2); endproperty
   property p_fall; $fell(act) && $past(rst_n_in) |-> !$past(st, 2); endproperty
   property p_hold; act && st |=> act; endproperty
   property p_bits; act || 1'b1 |-> job_ack_input_word_out[0] == 1'b0; endproperty
   property p_pulse; status_write_out |=> !status_write_out; endproperty
   property p_word;
      $changed(job_completion_status_word_out) && $past(rst_n_in) |-> status_write_out;
   endproperty
   property p_done; status_write_out |-> act; endproperty
   property p_rdata; !$past(rd_in) |-> rdata_out == 32'h0000_0000; endproperty
   a_rise: assert property (p_rise) else $error("active without start");
   a_fall: assert property (p_fall) else $error("active dropped early");
   a_hold: assert property (p_hold) else $error("active lost");
   a_bits: assert property (p_bits) else $error("spare ack bit set");
   a_pulse: assert property (p_pulse) else $error("long write pulse");
   a_word: assert property (p_word) else $error("silent word change");
   a_done: assert property (p_done) else $error("write outside job");
   a_rdata: assert property (p_rdata) else $error("stray read data");
   c_launch: cover property ($rose(act));
   c_ok: cover property (status_write_out && job_completion_status_word_out == 16'h0000);
   c_irq: cover property ($rose(irq_out));
endmodule // jsh_chk
bind jsh_job_start_handshake jsh_chk #(.WORD_W(WORD_W)) i_chk (
   .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
   .job_control_output_word_in(job_control_output_word_in),
   .job_ack_input_word_out(job_ack_input_word_out),
   .job_completion_status_word_out(job_completion_status_word_out),
   .status_write_out(status_write_out), .rd_in(rd_in), .rdata_out(rdata_out),
   .irq_out(irq_out));

// ==== sim/jsh_host_model.sv ====
/* Behavioural host controller that launches jobs on the start bit.
   Assumes the device answers on bit 1 of its acknowledge word. */
`timescale 1ns/1ps
module jsh_host_model #(parameter int TMO = 40) (
   input wire logic        clk_sys_in,
   input wire logic        rst_n_in,
   input wire logic        go_in,
   input wire logic        slow_in,
   input wire logic [15:0] ack_word_in,
   output logic [15:0]     ctrl_word_out,
   output logic            timed_out_out
);
   logic       busy_q;
   logic [7:0] cnt_q;
   always @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         ctrl_word_out <= 16'h0000;
         busy_q <= 1'b0;
         timed_out_out <= 1'b0;
      end else if (go_in && !busy_q && !ack_word_in[1]) begin
         ctrl_word_out[1] <= 1'b1;
         busy_q <= 1'b1;
         cnt_q <= 8'h00;
         timed_out_out <= 1'b0;
      end else if (busy_q) begin
         cnt_q <= cnt_q + 8'h01;
         if (ack_word_in[1] && (!slow_in || cnt_q[2])) begin
            ctrl_word_out[1] <= 1'b0;
            busy_q <= 1'b0;
         end else if (!ack_word_in[1] && cnt_q == TMO) begin
            ctrl_word_out[1] <= 1'b0;
            busy_q <= 1'b0;
            timed_out_out <= 1'b1;
         end
      end
   end
endmodule // jsh_host_model

// ==== sim/tb.sv ====
/* Self-checking bench for the job start handshake with a host model.
   Assumes a 100 MHz clock and a timeout tick shortened to four cycles. */
`timescale 1ns/1ps
module tb;
   logic        clk = 1'b0, rst_n = 1'b0, rst_h = 1'b0, go = 1'b0, slow = 1'b0;
   logic        wr_s = 1'b0, rd_s = 1'b0, swr, irq, tmo;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, d;
   logic [31:0] rdata;
   logic [15:0] ctrl, ack, word;
   int          errors = 0, num_checks = 0, seed = 75737;
   jsh_job_start_handshake #(.TICK_CYCLES(4)) i_dut (
      .clk_sys_in(clk), .rst_n_in(rst_n), .job_control_output_word_in(ctrl),
      .job_ack_input_word_out(ack), .job_completion_status_word_out(word),
      .status_write_out(swr), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s),
      .rd_in(rd_s), .rdata_out(rdata), .irq_out(irq));
   jsh_host_model i_host (.clk_sys_in(clk), .rst_n_in(rst_h), .go_in(go),
      .slow_in(slow), .ack_word_in(ack), .ctrl_word_out(ctrl), .timed_out_out(tmo));
   initial forever #5 clk = ~clk;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic launch;
      @(posedge clk);
      go <= 1'b1;
      slow <= 1'($random(seed));
      @(posedge clk);
      go <= 1'b0;
   endtask
   task automatic wait_ack(input logic lvl);
      for (int i = 0; i < 60 && ack[1] !== lvl; i++) @(posedge clk) #1;
      chk("job active", lvl, ack[1]);
   endtask
   // Kinds: 0 success, 1 failure with a code, 2 left to time out.
   task automatic job(input int kind, input logic [15:0] code);
      logic [15:0] e;
      e = (kind == 0) ? 16'h0000 : (kind == 2 || code == 16'h0000) ? 16'h00ff : code;
      launch();
      wait_ack(1'b1);
      if (kind != 2) wr(8'h00, {code, 13'h0000, kind == 1, kind == 0, 1'b1});
      for (int i = 0; i < 100 && swr !== 1'b1; i++) @(posedge clk) #1;
      chk("status write", 1'b1, swr);
      chk("status word", e, word);
      rd(8'h10, d);
      chk("result", e, d[31:16]);
      wait_ack(1'b0);
      rd(8'h04, d);
      chk("state idle", 2'h0, d[17:16]);
      rd(8'h08, d);
      chk("irq status", {kind == 2, 1'b1}, {d[2], d[0]});
      chk("irq level", 1'b1, irq);
      wr(8'h0c, 32'h0);
      #1 chk("irq masked", 1'b0, irq);
      wr(8'h0c, 32'hf);
      wr(8'h08, 32'hf);
      #1 chk("irq cleared", 1'b0, irq);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rst_h <= 1'b1;
      #1 chk("preset word", 16'h0001, word);
      rd(8'h14, d);
      chk("timeout default", 16'h001e, d[15:0]);
      chk("block words", 16'h00c8, d[31:16]);
      rd(8'h3c, d);
      chk("unmapped read", 32'h0, d);
      launch();
      repeat (4) @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      wr(8'h00, 32'h1);
      wr(8'h0c, 32'hf);
      for (int i = 0; i < 80 && tmo !== 1'b1; i++) @(posedge clk) #1;
      chk("stale start ignored", 1'b1, tmo);
      rd(8'h08, d);
      chk("stale seen", 1'b1, d[3]);
      wr(8'h08, 32'hf);
      wr(8'h14, 32'(($random(seed) & 3) | 1));
      for (int i = 0; i < 9; i++) job(i % 3, (i == 1) ? 16'h0000 : 16'($random(seed)));
      tally_and_finish();
   end
endmodule // tb
